// ===== src/cfg_lock_cfg.svh
`ifndef CFG_LOCK_CFG_SVH
`define CFG_LOCK_CFG_SVH

// Key values that open the bank.
`define CFG_KEY_FIRST      32'h83E70B13
`define CFG_KEY_SECOND     32'h95A4F1E0

// Register indices within the bank.
`define CFG_IDX_STATUS     4'h0
`define CFG_IDX_IDENT      4'h1
`define CFG_IDX_KEY_FIRST  4'hE
`define CFG_IDX_KEY_SECOND 4'hF

// Field position of the lock state inside the status register.
`define CFG_STATUS_LSB     0
`define CFG_STATUS_MSB     2

// Reset values.
`define CFG_BANK_RESET     32'h00000000
// Identity word; the value is arbitrary.
`define CFG_IDENT_VALUE    32'h00005A5A

`endif

// ===== src/cfg_lock_pkg.sv
package cfg_lock_pkg;

    // Lock states, one-hot.
    typedef enum logic [2:0]
    {
        LOCKED = 3'h1,
        ARMED  = 3'h2,
        OPEN   = 3'h4
    } lock_state_t;

    // One bus request: a read or a write to one word of the bank.
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } cfg_req_t;

    // Read answer.
    typedef struct packed
    {
        logic        valid;
        logic [31:0] data;
    } cfg_rsp_t;

endpackage : cfg_lock_pkg

// ===== src/config_register_write_lock.sv
`timescale 1ns/1ps
`include "cfg_lock_cfg.svh"
// Behaviour
// - After reset the bank is locked without any software action.
// - While locked, protected register writes are dropped; reads work.
// - First key then second key, in order, unlocks the bank.
// - Unlocked, writable registers take writes; read-only ones never do.
// - A wrong value written to either key register relocks the bank.
// - One key pair and one lock state shared by every bus master.
module config_register_write_lock #(
    parameter int          NREG    = 16,
    parameter logic [15:0] RO_MASK = 16'h0003
) (
    // Clock, reset and enable
    input  wire  logic                  ref_clk,
    input  wire  logic                  rst_n,
    input  wire  logic                  clk_en,
    // Request from the configuration bus
    input  wire  cfg_lock_pkg::cfg_req_t req,
    // Answers
    output       cfg_lock_pkg::cfg_rsp_t rsp,
    output logic                        wr_done,
    output logic                        wr_dropped,
    output logic                        locked
);
    import cfg_lock_pkg::*;

    //--------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------
    lock_state_t lock_state;
    lock_state_t next_lock_state;
    logic [31:0] bank [NREG];
    logic        is_key_first;
    logic        is_key_second;
    logic        is_key;
    logic        is_ro;
    logic        wr_go;
    logic        wr_accept;
    logic        first_ok;
    logic        second_ok;

    // Classify the addressed register.
    assign is_key_first  = (req.addr == `CFG_IDX_KEY_FIRST);
    assign is_key_second = (req.addr == `CFG_IDX_KEY_SECOND);
    assign is_key        = is_key_first | is_key_second;
    assign is_ro         = RO_MASK[req.addr];
    assign wr_go         = clk_en & req.wr;
    assign first_ok      = (req.wdata == `CFG_KEY_FIRST);
    assign second_ok     = (req.wdata == `CFG_KEY_SECOND);

    // A bank write lands only when unlocked and the target is writable.
    assign wr_accept = wr_go & ~is_key & ~is_ro
                     & (lock_state == OPEN);

    //--------------------------------------------------------------
    // Lock state
    //--------------------------------------------------------------
    // Next lock state from key writes; other writes leave it alone.
    always_comb
    begin
        next_lock_state = lock_state;
        if (wr_go && is_key_first)
        begin
            if (!first_ok)
                next_lock_state = LOCKED;
            else if (lock_state != OPEN)
                next_lock_state = ARMED;
        end
        else if (wr_go && is_key_second)
        begin
            if (second_ok && lock_state != LOCKED)
                next_lock_state = OPEN;
            else
                next_lock_state = LOCKED;
        end
    end

    // One lock register for the whole bank, whichever core writes.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            lock_state <= LOCKED;
        else if (clk_en)
            lock_state <= next_lock_state;
    end

    // Any state short of fully open counts as locked.
    assign locked = (lock_state != OPEN);

    //--------------------------------------------------------------
    // Register bank
    //--------------------------------------------------------------
    // Writable words take the data only when the write is accepted.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NREG; i++)
                bank[i] <= `CFG_BANK_RESET;
        end
        else if (wr_accept)
        begin
            bank[req.addr] <= req.wdata;
        end
    end

    // Write outcome pulses, one cycle after the request.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_done    <= 1'b0;
            wr_dropped <= 1'b0;
        end
        else if (clk_en)
        begin
            wr_done    <= req.wr & (wr_accept | is_key);
            wr_dropped <= req.wr & ~wr_accept & ~is_key;
        end
    end

    // Reads answer one cycle later whatever the lock state.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else if (clk_en)
        begin
            rsp.valid <= req.rd;
            if (req.addr == `CFG_IDX_STATUS)
            begin
                rsp.data <= '0;
                rsp.data[`CFG_STATUS_MSB:`CFG_STATUS_LSB] <= lock_state;
            end
            else if (req.addr == `CFG_IDX_IDENT)
                rsp.data <= `CFG_IDENT_VALUE;
            else if (is_key)
                rsp.data <= '0; // Keys read back as zero.
            else
                rsp.data <= bank[req.addr];
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    // First key taken while the bank is fully locked.
    sequence first_key_s;
        clk_en && req.wr && is_key_first && first_ok
            && lock_state == LOCKED;
    endsequence

    // Bank waiting for the second key.
    sequence armed_s;
        lock_state == ARMED;
    endsequence

    // Correct second key taken on an enabled edge.
    sequence second_key_s;
        clk_en && req.wr && is_key_second && second_ok;
    endsequence

    // Reset always leaves the bank locked.
    reset_locks_a: assert property (
        @(posedge ref_clk)
        !rst_n |=> lock_state == LOCKED)
        else $error("Bank not locked after reset.");

    // A write to a protected word while locked is reported as dropped.
    locked_drop_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && !is_key && lock_state != OPEN)
        |=> wr_dropped && !wr_done)
        else $error("Write landed while bank was locked.");

    // A dropped write leaves the addressed word as it was.
    locked_keep_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && !is_key && lock_state != OPEN)
        |=> bank[$past(req.addr)] == $past(bank[req.addr]))
        else $error("Locked word changed on a write.");

    // The first key alone only arms the bank.
    key_arm_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        first_key_s |=> armed_s)
        else $error("First key did not arm the bank.");

    // The second key after the first one opens the bank.
    unlock_seq_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        armed_s ##0 second_key_s |=> lock_state == OPEN && !locked)
        else $error("Key pair did not unlock the bank.");

    // An unlocked write to a writable word lands in the bank.
    open_accept_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && !is_key && !is_ro && lock_state == OPEN)
        |=> wr_done ##0 (bank[$past(req.addr)] == $past(req.wdata)))
        else $error("Unlocked write to writable register lost.");

    // Read-only words refuse every write.
    ro_ignore_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && is_ro) |=> wr_dropped && !wr_done)
        else $error("Read-only register accepted a write.");

    // A wrong value in either key register locks the bank.
    bad_key_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && ((is_key_first && !first_ok)
            || (is_key_second && !second_ok)))
        |=> lock_state == LOCKED ##1 (lock_state != OPEN))
        else $error("Wrong key value did not relock.");

    // Any reader sees the one shared lock state.
    status_view_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.rd && req.addr == `CFG_IDX_STATUS)
        |=> rsp.valid && rsp.data[2:0] == $past(lock_state))
        else $error("Status read does not show the lock state.");

    // Key words take writes in every lock state.
    key_always_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && req.wr && is_key) |=> wr_done && !wr_dropped)
        else $error("Key register write was refused.");

    // A low enable freezes the lock state and the write reports.
    freeze_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> $stable(lock_state) && $stable(wr_done)
            && $stable(wr_dropped))
        else $error("State moved while the enable was low.");

endmodule : config_register_write_lock

// ===== verif/bus_core.sv
`timescale 1ns/1ps
module bus_core
(
    // Bus clock
    input  wire logic                   ref_clk,
    // Request toward the bank
    output      cfg_lock_pkg::cfg_req_t req,
    // Answers from the bank
    input  wire cfg_lock_pkg::cfg_rsp_t rsp,
    input  wire logic                   wr_done,
    input  wire logic                   wr_dropped
);
    import cfg_lock_pkg::*;

    // Idle lines start with a pattern that does not look like a request.
    initial req = '{1'b0, 1'b0, 4'hA, 32'hA5A5A5A5};

    // Write one word; the request holds over the edge that takes it.
    task automatic write(input logic [3:0] a, input logic [31:0] d,
                         output logic done, output logic drop);
        @(posedge ref_clk);
        #1;
        req = '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        #1;
        req = '{1'b0, 1'b0, ~a, ~d};
        done = wr_done;
        drop = wr_dropped;
    endtask : write

    // Read one word; the answer stands for one cycle after the take.
    task automatic read(input logic [3:0] a, output cfg_rsp_t r);
        @(posedge ref_clk);
        #1;
        req = '{1'b0, 1'b1, a, 32'h5A5A5A5A};
        @(posedge ref_clk);
        #1;
        req = '{1'b0, 1'b0, ~a, 32'hC3C3C3C3};
        r = rsp;
    endtask : read
endmodule : bus_core

// ===== verif/config_register_write_lock_tb.sv
`timescale 1ns/1ps
`include "cfg_lock_cfg.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %0h got %0h", n, e, a); \
    end end
module config_register_write_lock_tb;
    import cfg_lock_pkg::*;
    logic     ref_clk = 1'b0;
    logic     rst_n   = 1'b0;
    logic     clk_en  = 1'b1;
    cfg_req_t req;
    cfg_rsp_t rsp, r;
    logic     wr_done, wr_dropped, locked, dn, dr;
    int       num_errors  = 0;
    int       comparisons = 0;

    // Clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    config_register_write_lock uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .req(req), .rsp(rsp), .wr_done(wr_done),
        .wr_dropped(wr_dropped), .locked(locked));
    bus_core core0 (.ref_clk(ref_clk), .req(req), .rsp(rsp),
        .wr_done(wr_done), .wr_dropped(wr_dropped));

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    // Checks the bank straight out of reset.
    task automatic t_reset;
        `CHK("locked", 1'b1, locked)
        core0.read(`CFG_IDX_STATUS, r);
        `CHK("status", 32'h1, r.data)
        core0.write(4'h5, 32'h1234, dn, dr);
        `CHK("dropped", 1'b1, dr)
        core0.read(4'h5, r);
        `CHK("valid", 1'b1, r.valid)
        `CHK("word5", 32'h0, r.data)
        $display("test reset done");
    endtask : t_reset

    // Unlocks with both keys and uses the open bank.
    task automatic t_unlock;
        core0.write(`CFG_IDX_KEY_FIRST, `CFG_KEY_FIRST, dn, dr);
        `CHK("key1 done", 1'b1, dn)
        `CHK("locked", 1'b1, locked)
        core0.write(`CFG_IDX_KEY_SECOND, `CFG_KEY_SECOND, dn, dr);
        `CHK("locked", 1'b0, locked)
        core0.read(`CFG_IDX_STATUS, r);
        `CHK("status open", 32'h4, r.data)
        core0.write(4'h5, 32'h1234, dn, dr);
        `CHK("done", 1'b1, dn)
        core0.read(4'h5, r);
        `CHK("word5", 32'h1234, r.data)
        core0.write(`CFG_IDX_IDENT, 32'h0, dn, dr);
        `CHK("ro dropped", 1'b1, dr)
        core0.read(`CFG_IDX_IDENT, r);
        `CHK("ident", `CFG_IDENT_VALUE, r.data)
        $display("test unlock done");
    endtask : t_unlock

    // A wrong key relocks the bank and protects its words again.
    task automatic t_relock;
        core0.write(`CFG_IDX_KEY_SECOND, 32'h0, dn, dr);
        `CHK("key done", 1'b1, dn)
        `CHK("locked", 1'b1, locked)
        core0.write(4'h5, 32'hBEEF, dn, dr);
        `CHK("dropped", 1'b1, dr)
        core0.read(4'h5, r);
        `CHK("word5", 32'h1234, r.data)
        $display("test relock done");
    endtask : t_relock

    // Keys out of order or wrong while armed leave the bank locked.
    task automatic t_order;
        core0.write(`CFG_IDX_KEY_SECOND, `CFG_KEY_SECOND, dn, dr);
        core0.write(`CFG_IDX_KEY_FIRST, `CFG_KEY_FIRST, dn, dr);
        `CHK("locked", 1'b1, locked)
        core0.write(`CFG_IDX_KEY_SECOND, `CFG_KEY_SECOND ^ 32'h1, dn, dr);
        core0.write(`CFG_IDX_KEY_SECOND, `CFG_KEY_SECOND, dn, dr);
        `CHK("locked", 1'b1, locked)
        $display("test order done");
    endtask : t_order

    // A low enable holds every request off, so nothing moves.
    task automatic t_freeze;
        core0.write(`CFG_IDX_KEY_FIRST, `CFG_KEY_FIRST, dn, dr);
        core0.write(`CFG_IDX_KEY_SECOND, `CFG_KEY_SECOND, dn, dr);
        clk_en = 1'b0;
        core0.write(`CFG_IDX_KEY_SECOND, 32'h0, dn, dr);
        core0.write(4'h5, 32'h5555, dn, dr);
        clk_en = 1'b1;
        `CHK("locked", 1'b0, locked)
        core0.read(4'h5, r);
        `CHK("word5", 32'h1234, r.data)
        $display("test freeze done");
    endtask : t_freeze

    // A second reset in mid-run locks the bank and clears its words.
    task automatic t_rereset;
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        `CHK("locked", 1'b1, locked)
        core0.read(4'h5, r);
        `CHK("word5", 32'h0, r.data)
        $display("test rereset done");
    endtask : t_rereset

    // Watchdog cuts a hang short.
    initial
    begin
        #20000;
        num_errors++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_unlock();
        t_relock();
        t_order();
        t_freeze();
        t_rereset();
        give_verdict();
    end
endmodule : config_register_write_lock_tb
